// ==== verilog/crc_pkg.sv ====
// Shared constants for the card reader channel control block.
// Assumes a 100 MHz logic clock and 16-bit instruction address fields.
package crc_pkg;
	localparam int CRC_CLK_FREQ_HZ = 100_000_000;
	localparam int CRC_WINDOW_MS = 10;
	localparam int CRC_RESTART_US = 100;
	localparam int CRC_WINDOW_CYC = CRC_WINDOW_MS * (CRC_CLK_FREQ_HZ / 1000);
	localparam int CRC_RESTART_CYC = CRC_RESTART_US * (CRC_CLK_FREQ_HZ / 1_000_000);
	localparam int CRC_COLS_PER_CARD = 80;
	localparam int CRC_CHAR_W = 6;
	localparam int CRC_FIFO_DEPTH = 4;
	// Instruction address layout: bit 0 class, bits 1-3 channel, bits 4-7 device.
	localparam int CRC_CLASS_BIT = 0;
	localparam int CRC_CHAN_LSB = 1;
	localparam int CRC_CHAN_MSB = 3;
	localparam int CRC_DEV_LSB = 4;
	localparam int CRC_DEV_MSB = 7;
	// Indicator select bits of a test-line instruction.
	localparam int CRC_SEL_ERROR = 8;
	localparam int CRC_SEL_OVERFLOW = 10;
	localparam int CRC_SEL_CYCLE = 12;
	localparam int CRC_SEL_READY = 13;
	localparam int CRC_SEL_BINARY = 15;
	// Function-line codes.
	localparam int CRC_FN_START = 15;
	localparam int CRC_FN_IRQ_EN = 14;
	localparam logic [6:0] CRC_COL_RESET = 7'h00;
	typedef enum logic [2:0] {
		CY_IDLE = 3'b001,
		CY_READ = 3'b010,
		CY_GAP = 3'b100
	} crc_cycle_type;
endpackage

// ==== verilog/crc_timer.sv ====
// One-shot cycle timer: start_i loads it, done_o pulses when it runs out.
// Assumes start_i is a single-cycle pulse; a new start restarts the count.
module crc_timer #(
	parameter int CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic abort_i,
	output logic running_o,
	output logic done_o
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (start_i) begin
			cnt_r <= W'(CYCLES);
		end else if (abort_i) begin
			cnt_r <= '0;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= !start_i && !abort_i && cnt_r == W'(1);
		end
	end

	assign running_o = cnt_r != '0;
endmodule // crc_timer

// ==== verilog/crc_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; a write into a full FIFO is refused by in_ready_o.
module crc_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_r[rd_r];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (flush_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= push ? wr_r + AW'(1) : wr_r;
			rd_r <= pop ? rd_r + AW'(1) : rd_r;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // crc_fifo

// ==== verilog/crc_reader.sv ====
// Card reader channel control: instruction decode, card cycle, connect window,
// continuous feed, channel signal, parity and interrupt requests.
// Assumes all inputs are synchronous to clk_i and strobes last one cycle.

// Function
// [RULE1] Test result follows selected indicator.
// [RULE2] Test addressed by channel, device, select bits.
// [RULE3] Functions: start cycle, set interrupt enable.
// [RULE4] Start rejected if busy or not ready.
// [RULE5] Enable rejected while another device connected.
// [RULE6] Start command or connect begins a cycle.
// [RULE7] Card moves at reader pace, channel independent.
// [RULE8] Connect rejected if not ready or late.
// [RULE9] Channel signal at card end while connected.
// [RULE10] Restart timer, then next card if connected.
// [RULE11] Parity on overflow, read or validity errors.
// [RULE12] Interrupt when connected and ready drops.
// [RULE13] Interrupt when idle channel, enabled, ready rises.
// [RULE14] Losing ready never cuts a cycle short.
// [RULE15] No reconnect until not-ready cause removed.
// [RULE16] Controller follows test, start, connect, transfer order.
// [RULE17] Cycle indicator set at start, cleared after 80.
// [RULE18] Overflow set on missed char, cleared three ways.
// [RULE19] Interrupt enable cleared on connect or clear.
// [RULE20] Timings counted in clock cycles from frequency.
// [RULE21] Reset clears indicators, enable and cycle.
module crc_reader
	import crc_pkg::*;
#(
	parameter logic [2:0] CHAN_NUM = 3'h0,
	parameter logic [3:0] DEV_NUM = 4'h1,
	parameter int WINDOW_CYC = CRC_WINDOW_CYC,
	parameter int RESTART_CYC = CRC_RESTART_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic test_line_instruction_i,
	input wire logic set_function_line_instruction_i,
	input wire logic [15:0] instr_addr_i,
	output logic test_result_o,
	output logic busy_o,
	input wire logic chan_connect_i,
	input wire logic chan_disconnect_i,
	input wire logic chan_clear_i,
	input wire logic other_dev_connected_i,
	output logic connected_o,
	output logic connect_reject_o,
	output logic chan_signal_o,
	output logic chan_parity_o,
	output logic chan_irq_o,
	output logic [CRC_CHAR_W-1:0] chan_data_o,
	output logic chan_valid_o,
	input wire logic chan_ready_i,
	input wire logic reader_ready_i,
	input wire logic char_valid_i,
	input wire logic [CRC_CHAR_W-1:0] char_data_i,
	input wire logic col_end_i,
	input wire logic binary_punch_i,
	input wire logic read_check_i,
	input wire logic validity_err_i,
	output logic card_feed_o,
	output logic cycle_active_o,
	output logic overflow_o,
	output logic reader_error_o,
	output logic binary_mode_o,
	output logic device_irq_enable_switch_o
);
	crc_cycle_type state_r;
	crc_cycle_type state_nxt;
	logic [6:0] col_r;
	logic connected_r;
	logic overflow_r;
	logic error_r;
	logic binary_r;
	logic device_irq_enable_switch_r;
	logic ready_prev_r;
	logic win_expired_r;
	logic addr_hit;
	logic test_hit;
	logic fn_hit;
	logic start_req;
	logic start_ok;
	logic irq_en_req;
	logic irq_en_ok;
	logic connect_ok;
	logic cycle_begin;
	logic card_end;
	logic win_done;
	logic gap_done;
	logic gap_running;
	logic fifo_in_ready;
	logic overflow_evt;
	logic test_value;
	logic any_connected;

	// Address decode; unused positions are ignored.
	assign addr_hit = instr_addr_i[CRC_CHAN_MSB:CRC_CHAN_LSB] == CHAN_NUM
		&& instr_addr_i[CRC_DEV_MSB:CRC_DEV_LSB] == DEV_NUM; // RULE2 RULE3
	assign test_hit = test_line_instruction_i && addr_hit;
	assign fn_hit = set_function_line_instruction_i && addr_hit
		&& !instr_addr_i[CRC_CLASS_BIT];
	assign start_req = fn_hit && instr_addr_i[CRC_FN_START]; // RULE3
	assign irq_en_req = fn_hit && instr_addr_i[CRC_FN_IRQ_EN]; // RULE3
	assign start_ok = start_req && state_r == CY_IDLE && reader_ready_i; // RULE4
	assign irq_en_ok = irq_en_req && !other_dev_connected_i; // RULE5
	assign any_connected = connected_r || other_dev_connected_i;

	// A late connect only counts against a cycle already under way.
	assign connect_ok = chan_connect_i && !connected_r && reader_ready_i // RULE15
		&& !(state_r == CY_READ && win_expired_r); // RULE8
	assign card_end = state_r == CY_READ && col_end_i
		&& col_r == 7'(CRC_COLS_PER_CARD - 1); // RULE17
	assign cycle_begin = start_ok // RULE6
		|| (connect_ok && state_r == CY_IDLE) // RULE6
		|| (gap_done && connected_r && !chan_disconnect_i); // RULE10

	// Overflow arises when the channel leaves the FIFO full as a character lands.
	assign overflow_evt = connected_r && char_valid_i && !fifo_in_ready; // RULE18

	always_comb begin
		test_value = 1'b0;
		if (instr_addr_i[CRC_CLASS_BIT]) begin
			test_value = instr_addr_i[CRC_SEL_OVERFLOW] && overflow_r;
		end else begin
			test_value = (instr_addr_i[CRC_SEL_ERROR] && error_r)
				|| (instr_addr_i[CRC_SEL_CYCLE] && state_r == CY_READ)
				|| (instr_addr_i[CRC_SEL_READY] && reader_ready_i)
				|| (instr_addr_i[CRC_SEL_BINARY] && binary_r); // RULE2
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CY_IDLE: begin
				if (cycle_begin) begin
					state_nxt = CY_READ; // RULE17
				end
			end
			// Ready is not consulted here, so a card in flight always completes.
			CY_READ: begin
				if (card_end) begin
					state_nxt = connected_r ? CY_GAP : CY_IDLE; // RULE14
				end
			end
			CY_GAP: begin
				if (!connected_r || chan_disconnect_i || chan_clear_i) begin
					state_nxt = CY_IDLE;
				end else if (gap_done) begin
					state_nxt = CY_READ; // RULE10
				end
			end
			default: begin
				state_nxt = CY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= CY_IDLE; // RULE21
		end else begin
			state_r <= state_nxt;
		end
	end

	// Columns are counted at the reader's own strobe rate.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			col_r <= CRC_COL_RESET;
		end else if (cycle_begin || card_end) begin
			col_r <= CRC_COL_RESET;
		end else if (state_r == CY_READ && col_end_i) begin
			col_r <= col_r + 7'h01; // RULE7
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			connected_r <= 1'b0;
		end else if (chan_disconnect_i || chan_clear_i) begin
			connected_r <= 1'b0;
		end else if (connect_ok) begin
			connected_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			connect_reject_o <= 1'b0;
		end else begin
			connect_reject_o <= chan_connect_i && !connect_ok; // RULE8
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overflow_r <= 1'b0; // RULE21
		end else if (overflow_evt) begin
			overflow_r <= 1'b1; // RULE18
		end else if ((test_hit && instr_addr_i[CRC_CLASS_BIT]) || chan_clear_i || connect_ok) begin
			overflow_r <= 1'b0; // RULE18
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			error_r <= 1'b0; // RULE21
		end else if (read_check_i || validity_err_i) begin
			error_r <= 1'b1;
		end else if (chan_clear_i || connect_ok) begin
			error_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			binary_r <= 1'b0; // RULE21
		end else if (binary_punch_i && state_r == CY_READ) begin
			binary_r <= 1'b1;
		end else if (chan_clear_i || cycle_begin) begin
			binary_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			device_irq_enable_switch_r <= 1'b0; // RULE21
		end else if (any_connected || chan_clear_i || connect_ok) begin
			device_irq_enable_switch_r <= 1'b0; // RULE19
		end else if (irq_en_ok) begin
			device_irq_enable_switch_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			test_result_o <= 1'b0;
		end else if (test_hit) begin
			test_result_o <= test_value; // RULE1
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= (start_req && !start_ok) || (irq_en_req && !irq_en_ok); // RULE4 RULE5
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_signal_o <= 1'b0;
		end else begin
			chan_signal_o <= card_end && connected_r; // RULE9
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_parity_o <= 1'b0;
		end else begin
			chan_parity_o <= connected_r && (overflow_evt || read_check_i || validity_err_i); // RULE11
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_prev_r <= 1'b0;
		end else begin
			ready_prev_r <= reader_ready_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chan_irq_o <= 1'b0;
		end else begin
			chan_irq_o <= (connected_r && ready_prev_r && !reader_ready_i) // RULE12
				|| (!any_connected && device_irq_enable_switch_r
				&& !ready_prev_r && reader_ready_i); // RULE13
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_expired_r <= 1'b0;
		end else if (cycle_begin) begin
			win_expired_r <= 1'b0;
		end else if (win_done) begin
			win_expired_r <= 1'b1; // RULE8
		end
	end

	crc_timer #(.CYCLES(WINDOW_CYC)) u_window ( // RULE20
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.start_i(cycle_begin),
		.abort_i(1'b0),
		.running_o(),
		.done_o(win_done)
	);

	crc_timer #(.CYCLES(RESTART_CYC)) u_restart ( // RULE20
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.start_i(card_end && connected_r), // RULE10
		.abort_i(!connected_r),
		.running_o(gap_running),
		.done_o(gap_done)
	);

	// Characters reach the channel only while connected; otherwise the card is skipped.
	crc_fifo #(.WIDTH(CRC_CHAR_W), .DEPTH(CRC_FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(chan_clear_i || connect_ok),
		.in_valid_i(char_valid_i && connected_r),
		.in_ready_o(fifo_in_ready),
		.in_data_i(char_data_i),
		.out_valid_o(chan_valid_o),
		.out_ready_i(chan_ready_i),
		.out_data_o(chan_data_o)
	);

	assign connected_o = connected_r;
	assign card_feed_o = state_r == CY_READ; // RULE7
	assign cycle_active_o = state_r == CY_READ; // RULE17
	assign overflow_o = overflow_r;
	assign reader_error_o = error_r;
	assign binary_mode_o = binary_r;
	assign device_irq_enable_switch_o = device_irq_enable_switch_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_card_end_conn;
		card_end && connected_r && !chan_disconnect_i && !chan_clear_i;
	endsequence
	sequence s_signal_then_gap;
		chan_signal_o && gap_running;
	endsequence

	a_test_result_follows: assert property (test_hit |=> test_result_o == $past(test_value)) // RULE1
		else $error("test result does not follow indicator");
	a_start_reject_busy: assert property (start_req && !reader_ready_i |=> busy_o && !$rose(cycle_active_o)) // RULE4
		else $error("start not rejected when not ready");
	a_irq_en_reject: assert property (irq_en_req && other_dev_connected_i |=> busy_o && !device_irq_enable_switch_o) // RULE5
		else $error("enable not rejected while other device connected");
	a_start_begins_cycle: assert property (start_ok |=> cycle_active_o && card_feed_o) // RULE6
		else $error("accepted start did not begin a cycle");
	a_connect_not_ready: assert property (chan_connect_i && !connected_r && !reader_ready_i |=> connect_reject_o && !connected_o) // RULE8
		else $error("connect accepted while not ready");
	a_card_end_signal: assert property (s_card_end_conn |=> s_signal_then_gap ##1 !chan_signal_o) // RULE9
		else $error("channel signal missing at card end");
	a_restart_next: assert property (gap_done && connected_r && !chan_disconnect_i && !chan_clear_i |=> cycle_active_o) // RULE10
		else $error("no automatic restart after gap");
	a_parity_on_error: assert property (connected_r && read_check_i |=> chan_parity_o) // RULE11
		else $error("parity not raised on read check");
	a_irq_ready_drop: assert property (connected_r && $fell(reader_ready_i) |=> chan_irq_o) // RULE12
		else $error("no interrupt on ready drop");
	a_cycle_holds: assert property (cycle_active_o && !reader_ready_i && !card_end |=> cycle_active_o) // RULE14
		else $error("cycle cut short by ready loss");
	a_overflow_set: assert property (overflow_evt |=> overflow_o [*2]) // RULE18
		else $error("overflow indicator not held");
	a_irq_en_cleared: assert property (connected_r || chan_clear_i |=> !device_irq_enable_switch_o) // RULE19
		else $error("interrupt enable not cleared");
endmodule // crc_reader

// ==== tb/crc_station_model.sv ====
// Behavioural read station of the card reader: emits one character and a
// column-end strobe every GAP cycles while the card is fed.
// Assumes feed_i is the controller's card feed level; outputs change at falling edges.
module crc_station_model #(
	parameter int GAP = 8
) (
	input wire logic clk_i,
	input wire logic feed_i,
	output logic char_valid_o,
	output logic [5:0] char_data_o,
	output logic col_end_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	int col = 0;
	initial begin
		char_valid_o = 1'b0;
		col_end_o = 1'b0;
		char_data_o = 6'h00;
	end
	// Columns come at the station's own pace, whatever the channel does.
	always @(negedge clk_i) begin
		char_valid_o <= 1'b0;
		col_end_o <= 1'b0;
		char_data_o <= ~char_data_o;
		if (!feed_i) begin
			cnt <= 0;
			col <= 0;
		end else if (cnt == GAP - 1) begin
			cnt <= 0;
			col <= col + 1;
			char_valid_o <= 1'b1;
			col_end_o <= 1'b1;
			char_data_o <= 6'(col % 80);
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // crc_station_model

// ==== tb/crc_tb.sv ====
// Self-checking bench for the card reader channel control block.
// Assumes the station model above and shortened window and restart counts.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench
	import crc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WIN = 200;
	localparam int RST = 20;
	localparam logic [2:0] CH = 3'h5;
	localparam logic [3:0] DV = 4'h9;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic test_line_instruction = 1'b0, set_function_line_instruction = 1'b0, conn = 1'b0, disc = 1'b0, clr = 1'b0, other = 1'b0;
	logic chan_ready_i = 1'b1, ready = 1'b1, punch = 1'b0, rdchk = 1'b0, verr = 1'b0;
	logic [15:0] instr_addr_i = 16'h0000;
	logic test_result_o, busy_o, connected_o, connect_reject_o, chan_signal_o, chan_parity_o, chan_irq_o;
	logic chan_valid_o, card_feed_o, cycle_active_o, overflow_o, reader_error_o, binary_mode_o, irq_en;
	logic char_valid, col_end;
	logic [5:0] char_data, chan_data_o;
	int error_cnt = 0, compares = 0;
	int n_busy = 0, n_sig = 0, n_irq = 0, n_rej = 0, n_par = 0, pops = 0;
	int n, b0, s0, i0, r0, p0;
	always #5 clk_i = ~clk_i;
	crc_reader #(.CHAN_NUM(CH), .DEV_NUM(DV), .WINDOW_CYC(WIN), .RESTART_CYC(RST)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .test_line_instruction_i(test_line_instruction), .set_function_line_instruction_i(set_function_line_instruction),
		.instr_addr_i(instr_addr_i), .test_result_o(test_result_o), .busy_o(busy_o), .chan_connect_i(conn),
		.chan_disconnect_i(disc), .chan_clear_i(clr), .other_dev_connected_i(other), .connected_o(connected_o),
		.connect_reject_o(connect_reject_o), .chan_signal_o(chan_signal_o), .chan_parity_o(chan_parity_o),
		.chan_irq_o(chan_irq_o), .chan_data_o(chan_data_o), .chan_valid_o(chan_valid_o), .chan_ready_i(chan_ready_i),
		.reader_ready_i(ready), .char_valid_i(char_valid), .char_data_i(char_data), .col_end_i(col_end),
		.binary_punch_i(punch), .read_check_i(rdchk), .validity_err_i(verr), .card_feed_o(card_feed_o),
		.cycle_active_o(cycle_active_o), .overflow_o(overflow_o), .reader_error_o(reader_error_o),
		.binary_mode_o(binary_mode_o), .device_irq_enable_switch_o(irq_en));
	crc_station_model #(.GAP(8)) i_station (.clk_i(clk_i), .feed_i(card_feed_o), .char_valid_o(char_valid),
		.char_data_o(char_data), .col_end_o(col_end));
	// Pulse outputs are counted so that checks do not hang on their exact latency.
	always @(posedge clk_i) begin
		if (busy_o === 1'b1) n_busy++;
		if (chan_signal_o === 1'b1) n_sig++;
		if (chan_irq_o === 1'b1) n_irq++;
		if (connect_reject_o === 1'b1) n_rej++;
		if (chan_parity_o === 1'b1) n_par++;
		if (chan_valid_o === 1'b1 && chan_ready_i === 1'b1) begin
			if (pops < 80) `CHK(chan_data_o, 6'(pops % 80))
			pops++;
		end
	end
	function automatic logic [15:0] adr(input logic cls, input int sel, input logic [3:0] dev);
		adr = 16'h0000;
		adr[CRC_CLASS_BIT] = cls;
		adr[CRC_CHAN_MSB:CRC_CHAN_LSB] = CH;
		adr[CRC_DEV_MSB:CRC_DEV_LSB] = dev;
		if (sel >= 0) adr[sel] = 1'b1;
	endfunction
	task automatic instr(input logic fn, input logic [15:0] a);
		@(negedge clk_i);
		instr_addr_i = a;
		if (fn) set_function_line_instruction = 1'b1;
		else test_line_instruction = 1'b1;
		@(negedge clk_i);
		test_line_instruction = 1'b0;
		set_function_line_instruction = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic wait_cyc(input logic lvl, output int cnt);
		for (cnt = 0; cnt < 2000 && cycle_active_o !== lvl; cnt++) @(negedge clk_i);
	endtask
	task automatic summarize();
		if (error_cnt == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		`CHK({cycle_active_o, overflow_o, irq_en, connected_o, test_result_o, binary_mode_o}, 6'h00)
		instr(1'b0, adr(1'b0, CRC_SEL_READY, DV));
		`CHK(test_result_o, 1'b1)
		ready = 1'b0;
		instr(1'b0, adr(1'b0, CRC_SEL_READY, 4'h3));
		`CHK(test_result_o, 1'b1)
		instr(1'b0, adr(1'b0, CRC_SEL_READY, DV));
		`CHK(test_result_o, 1'b0)
		{b0, i0} = {n_busy, n_irq};
		other = 1'b1;
		instr(1'b1, adr(1'b0, CRC_FN_IRQ_EN, DV));
		`CHK({n_busy - b0, irq_en}, {32'd1, 1'b0})
		other = 1'b0;
		instr(1'b1, adr(1'b0, CRC_FN_IRQ_EN, DV));
		`CHK({n_busy - b0, irq_en}, {32'd1, 1'b1})
		ready = 1'b1;
		repeat (3) @(negedge clk_i);
		`CHK(n_irq - i0, 1)
		instr(1'b1, adr(1'b0, CRC_FN_START, DV));
		`CHK({n_busy - b0, cycle_active_o}, {32'd1, 1'b1})
		pulse(conn);
		`CHK({connected_o, irq_en}, 2'b10)
		instr(1'b1, adr(1'b0, CRC_FN_START, DV));
		`CHK(n_busy - b0, 2)
		instr(1'b0, adr(1'b0, CRC_SEL_CYCLE, DV));
		`CHK(test_result_o, 1'b1)
		pulse(punch);
		instr(1'b0, adr(1'b0, CRC_SEL_BINARY, DV));
		`CHK({test_result_o, binary_mode_o}, 2'b11)
		s0 = n_sig;
		wait_cyc(1'b0, n);
		repeat (2) @(negedge clk_i);
		`CHK({n_sig - s0, pops}, {32'd1, 32'd80})
		wait_cyc(1'b1, n);
		// The count starts two cycles after the card end, so those two are added back.
		`CHK(n + 2 >= RST && n + 2 <= RST + 6, 1'b1)
		chan_ready_i = 1'b0;
		p0 = n_par;
		for (n = 0; n < 200 && overflow_o !== 1'b1; n++) @(negedge clk_i);
		// The parity pulse is counted one edge after the overflow flag shows.
		@(negedge clk_i);
		`CHK({overflow_o, n_par > p0}, 2'b11)
		{i0, s0, p0} = {n_irq, n_sig, n_par};
		ready = 1'b0;
		pulse(rdchk);
		`CHK({n_irq - i0, n_par > p0, reader_error_o}, {32'd1, 2'b11})
		chan_ready_i = 1'b1;
		repeat (2) @(negedge clk_i);
		p0 = n_par;
		pulse(verr);
		`CHK(n_par - p0, 1)
		wait_cyc(1'b0, n);
		pulse(disc);
		`CHK({n_sig - s0, connected_o}, {32'd1, 1'b0})
		instr(1'b0, adr(1'b1, CRC_SEL_OVERFLOW, DV));
		`CHK({test_result_o, overflow_o}, 2'b10)
		r0 = n_rej;
		pulse(conn);
		`CHK({n_rej - r0, connected_o}, {32'd1, 1'b0})
		ready = 1'b1;
		instr(1'b1, adr(1'b0, CRC_FN_START, DV));
		repeat (WIN + 10) @(negedge clk_i);
		pulse(conn);
		`CHK({n_rej - r0, connected_o, cycle_active_o}, {32'd2, 2'b01})
		wait_cyc(1'b0, n);
		pulse(conn);
		`CHK({connected_o, cycle_active_o}, 2'b11)
		pulse(clr);
		`CHK(connected_o, 1'b0)
		summarize();
	end
endmodule // testbench
